// file: design/fpcs_pkg.sv
/*
 * fpcs_pkg: constants of the fractional pll clock source block.
 * register indices, field positions, reset values and lock timing.
 * assumes a 125 MHz system clock and a 32-bit apb register bus.
 */
package fpcs_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_ROOT_SEL  = 6'h04;
	localparam logic [5:0] IDX_PLL_CTRL  = 6'h05;
	localparam logic [5:0] IDX_PLL_J     = 6'h06;
	localparam logic [5:0] IDX_FRAC_UP   = 6'h07;
	localparam logic [5:0] IDX_FRAC_LO   = 6'h08;
	localparam logic [5:0] IDX_STATUS    = 6'h09;

	// root clock select register fields
	localparam int ROOT_SRC_LSB  = 0;
	localparam int ROOT_SRC_W    = 2;
	localparam int RANGE_BIT     = 6;

	// pll control register fields
	localparam int EN_BIT        = 7;
	localparam int P_LSB         = 4;
	localparam int P_W           = 3;
	localparam int R_LSB         = 0;
	localparam int R_W           = 4;

	// multiplier and fraction fields
	localparam int J_LSB         = 0;
	localparam int J_W           = 6;
	localparam int DUP_LSB       = 0;
	localparam int DUP_W         = 6;
	localparam int DLO_LSB       = 0;
	localparam int DLO_W         = 8;
	localparam int D_W           = DUP_W + DLO_W;

	// status register fields
	localparam int ST_GPIO_BIT   = 0;
	localparam int ST_LOCK_BIT   = 1;
	localparam int ST_RBAD_BIT   = 2;
	localparam int ST_DBAD_BIT   = 3;

	// reset values
	localparam logic [7:0] RST_ROOT_SEL = 8'h00;
	localparam logic [7:0] RST_PLL_CTRL = 8'h11;
	localparam logic [7:0] RST_PLL_J    = 8'h04;
	localparam logic [7:0] RST_FRAC     = 8'h00;
	localparam logic [7:0] RST_STATUS   = 8'h00;

	// largest legal fraction
	localparam logic [D_W-1:0] D_MAX    = 14'h270F;

	// root clock source codes
	localparam logic [1:0] SRC_MCLK = 2'h0;
	localparam logic [1:0] SRC_BCLK = 2'h1;
	localparam logic [1:0] SRC_GPIO = 2'h2;
	localparam logic [1:0] SRC_PLL  = 2'h3;

	// lock interval: time in microseconds, clock in MHz
	localparam int LOCK_TIME_US  = 10000;
	localparam int CLK_MHZ       = 125;
	localparam int LOCK_CYCLES   = LOCK_TIME_US * CLK_MHZ;
	localparam int LOCK_CNT_W    = 21;

	// pll sequencing states
	typedef enum logic [1:0] {
		PLL_OFF,
		PLL_LOCKING,
		PLL_LOCKED
	} fpcs_state_t;

endpackage : fpcs_pkg

// file: design/fpcs_top.sv
/*
 * fpcs_top: control logic of a fractional pll and the converter
 * root clock selector, with an apb register slave.
 * assumes an analog pll core outside that takes the enable and the
 * p, r, j and d settings and returns its output clock; all clocks
 * from pins are sampled on CLK_I, so the root clock output is a
 * sampled copy, usable only for clocks well below CLK_I.
 */
// Chosen here: the APB slave port.
`timescale 1ns/1ps

module fpcs_top #(
	parameter int LOCK_CYCLES_P = fpcs_pkg::LOCK_CYCLES
) (
	// clock and reset
	input  wire logic                        CLK_I,
	input  wire logic                        ARST_N_I,
	// apb slave
	input  wire logic                        PSEL_I,
	input  wire logic                        PENABLE_I,
	input  wire logic                        PWRITE_I,
	input  wire logic [7:0]                  PADDR_I,
	input  wire logic [31:0]                 PWDATA_I,
	output logic      [31:0]                 PRDATA_O,
	output logic                             PREADY_O,
	output logic                             PSLVERR_O,
	// clock pins and analog pll core output
	input  wire logic                        MCLK_I,
	input  wire logic                        BCLK_I,
	input  wire logic                        GPIO_CLK_I,
	input  wire logic                        PLL_CORE_CLK_I,
	// settings to the analog pll core
	output logic                             PLL_EN_O,
	output logic [3:0]                       PLL_P_O,
	output logic [fpcs_pkg::R_W-1:0]         PLL_R_O,
	output logic [fpcs_pkg::J_W-1:0]         PLL_J_O,
	output logic [fpcs_pkg::D_W-1:0]         PLL_D_O,
	output logic                             PLL_RANGE_O,
	// clock results
	output logic                             PLL_LOCKED_O,
	output logic                             PLL_CLK_O,
	output logic                             PLL_GPIO_CLK_O,
	output logic                             ROOT_CLK_O,
	output logic [1:0]                       ROOT_SEL_O
);
	import fpcs_pkg::*;

	// register storage
	logic [7:0]          root_sel_r;
	logic [7:0]          pll_ctrl_r;
	logic [7:0]          pll_j_r;
	logic [DUP_W-1:0]    frac_up_r;
	logic [DLO_W-1:0]    frac_lo_r;
	logic [D_W-1:0]      frac_act_r;
	logic                gpio_route_r;

	// bus handshake
	logic                access;
	logic                wr_en;
	logic [5:0]          idx;
	logic                idx_ok;
	logic [7:0]          rd_byte;

	// synchronisers: mclk, bclk, gpio, pll core
	logic [3:0]          sync1_r;
	logic [3:0]          sync2_r;

	// sequencing
	fpcs_state_t         state_r;
	fpcs_state_t         state_nxt;
	logic [LOCK_CNT_W-1:0] lock_cnt_r;
	logic                pll_want;
	logic                r_bad;
	logic                d_bad;
	logic                lock_done;
	logic [LOCK_CNT_W-1:0] lock_last;

	// last count of the lock interval; the counter stops there, so
	// lock_done stays up without a wrap back to zero
	assign lock_last = LOCK_CNT_W'(LOCK_CYCLES_P - 1);

	// an unmapped index still gets an answer, so a stray address
	// never hangs the bus
	// apb decode; answer comes one cycle into the access phase
	assign access = PSEL_I & PENABLE_I & PREADY_O;
	assign wr_en  = access & PWRITE_I & idx_ok;
	assign idx    = PADDR_I[7:2];
	always_comb begin
		idx_ok = 1'b1;
		case (idx)
			IDX_ROOT_SEL, IDX_PLL_CTRL, IDX_PLL_J,
			IDX_FRAC_UP, IDX_FRAC_LO, IDX_STATUS: idx_ok = 1'b1;
			default: idx_ok = 1'b0;
		endcase
	end

	// pready pulses once per access, so every transfer waits one cycle
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O  <= PSEL_I & PENABLE_I & ~PREADY_O;
			PSLVERR_O <= PSEL_I & PENABLE_I & ~PREADY_O & ~idx_ok;
		end
	end

	// read data mux; unmapped reads return zero with pslverr
	always_comb begin
		rd_byte = 8'h00;
		case (idx)
			IDX_ROOT_SEL: rd_byte = root_sel_r;
			IDX_PLL_CTRL: rd_byte = pll_ctrl_r;
			IDX_PLL_J:    rd_byte = pll_j_r;
			IDX_FRAC_UP:  rd_byte = {2'b00, frac_up_r};
			IDX_FRAC_LO:  rd_byte = frac_lo_r;
			IDX_STATUS: begin
				rd_byte[ST_GPIO_BIT] = gpio_route_r;
				rd_byte[ST_LOCK_BIT] = PLL_LOCKED_O;
				rd_byte[ST_RBAD_BIT] = r_bad;
				rd_byte[ST_DBAD_BIT] = d_bad;
			end
			default: rd_byte = 8'h00;
		endcase
	end

	// read data is captured while the answer is prepared
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			PRDATA_O <= 32'h0000_0000;
		end else if (PSEL_I & PENABLE_I & ~PREADY_O) begin
			PRDATA_O <= {24'h00_0000, rd_byte};
		end
	end

	// clock select register: source code and range-mode bit
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			root_sel_r <= RST_ROOT_SEL;
		end else if (wr_en && idx == IDX_ROOT_SEL) begin
			root_sel_r <= PWDATA_I[7:0];
		end
	end

	// pll control register: enable, p and r
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			pll_ctrl_r <= RST_PLL_CTRL;
		end else if (wr_en && idx == IDX_PLL_CTRL) begin
			pll_ctrl_r <= PWDATA_I[7:0];
		end
	end

	// integer multiplier register
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			pll_j_r <= RST_PLL_J;
		end else if (wr_en && idx == IDX_PLL_J) begin
			pll_j_r <= PWDATA_I[7:0];
		end
	end

	// fraction: upper half waits in its register until the lower
	// half is written, so the core never sees a half-updated d
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			frac_up_r  <= DUP_W'(RST_FRAC);
			frac_lo_r  <= DLO_W'(RST_FRAC);
			frac_act_r <= D_W'(RST_FRAC);
		end else begin
			if (wr_en && idx == IDX_FRAC_UP) begin
				frac_up_r <= PWDATA_I[DUP_LSB +: DUP_W];
			end
			if (wr_en && idx == IDX_FRAC_LO) begin
				frac_lo_r  <= PWDATA_I[DLO_LSB +: DLO_W];
				frac_act_r <= {frac_up_r,
					PWDATA_I[DLO_LSB +: DLO_W]};
			end
		end
	end

	// gpio routing bit in the status register
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			gpio_route_r <= RST_STATUS[ST_GPIO_BIT];
		end else if (wr_en && idx == IDX_STATUS) begin
			gpio_route_r <= PWDATA_I[ST_GPIO_BIT];
		end
	end

	// two-stage synchronisers for every clock arriving from outside
	// a pin clock must stay well below half of CLK_I or edges are lost
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge CLK_I or negedge ARST_N_I) begin
				if (!ARST_N_I) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
				end else begin
					sync1_r[gi] <= (gi == 0) ? MCLK_I :
						(gi == 1) ? BCLK_I :
						(gi == 2) ? GPIO_CLK_I : PLL_CORE_CLK_I;
					sync2_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate

	// settings checks; out-of-range r keeps the pll off
	// a bad fraction or j only shows in status: the core keeps running
	// and software is expected to repair the setting
	assign r_bad     = (pll_ctrl_r[R_LSB +: R_W] == 4'h0) |
		(pll_ctrl_r[R_LSB +: R_W] > 4'h4);
	assign d_bad     = (frac_act_r > D_MAX) |
		(pll_j_r[J_LSB +: J_W] == 6'h00);
	assign pll_want  = pll_ctrl_r[EN_BIT] & ~r_bad;
	assign lock_done = (lock_cnt_r >= lock_last);

	// sequencing: off, counting the lock interval, locked
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			PLL_OFF: begin
				if (pll_want) begin
					state_nxt = PLL_LOCKING;
				end
			end
			PLL_LOCKING: begin
				if (!pll_want) begin
					state_nxt = PLL_OFF;
				end else if (lock_done) begin
					state_nxt = PLL_LOCKED;
				end
			end
			PLL_LOCKED: begin
				if (!pll_want) begin
					state_nxt = PLL_OFF;
				end
			end
			default: state_nxt = PLL_OFF;
		endcase
	end

	// state register
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			state_r <= PLL_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	// lock counter restarts from zero at every enable
	// the count is a fixed delay, not a measured lock: the analog core
	// gives no lock indication of its own
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			lock_cnt_r <= '0;
		end else if (state_r != PLL_LOCKING) begin
			lock_cnt_r <= '0;
		end else if (!lock_done) begin
			lock_cnt_r <= lock_cnt_r + 1'b1;
		end
	end

	// settings to the analog core; p code 0 stands for 8
	// settings follow the registers even while locked, so software
	// should disable the pll before it retunes p, r or j
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			PLL_EN_O    <= 1'b0;
			PLL_P_O     <= {1'b0, RST_PLL_CTRL[P_LSB +: P_W]};
			PLL_R_O     <= R_W'(RST_PLL_CTRL);
			PLL_J_O     <= J_W'(RST_PLL_J);
			PLL_D_O     <= D_W'(RST_FRAC);
			PLL_RANGE_O <= 1'b0;
		end else begin
			PLL_EN_O    <= (state_nxt != PLL_OFF);
			PLL_P_O     <= (pll_ctrl_r[P_LSB +: P_W] == 3'h0) ? 4'h8 :
				{1'b0, pll_ctrl_r[P_LSB +: P_W]};
			PLL_R_O     <= pll_ctrl_r[R_LSB +: R_W];
			PLL_J_O     <= pll_j_r[J_LSB +: J_W];
			PLL_D_O     <= frac_act_r;
			PLL_RANGE_O <= root_sel_r[RANGE_BIT];
		end
	end

	// gated pll clock; gating drops at once when disabled
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			PLL_LOCKED_O   <= 1'b0;
			PLL_CLK_O      <= 1'b0;
			PLL_GPIO_CLK_O <= 1'b0;
		end else begin
			PLL_LOCKED_O   <= (state_nxt == PLL_LOCKED);
			PLL_CLK_O      <= sync2_r[3] &
				(state_nxt == PLL_LOCKED);
			PLL_GPIO_CLK_O <= sync2_r[3] & gpio_route_r &
				(state_nxt == PLL_LOCKED);
		end
	end

	// root clock selector; the pll leg is already gated
	// a source change may clip one pulse of the root clock, so the
	// converters should be held idle while the source changes
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ROOT_CLK_O <= 1'b0;
			ROOT_SEL_O <= SRC_MCLK;
		end else begin
			ROOT_SEL_O <= root_sel_r[ROOT_SRC_LSB +: ROOT_SRC_W];
			case (root_sel_r[ROOT_SRC_LSB +: ROOT_SRC_W])
				SRC_MCLK: ROOT_CLK_O <= sync2_r[0];
				SRC_BCLK: ROOT_CLK_O <= sync2_r[1];
				SRC_GPIO: ROOT_CLK_O <= sync2_r[2];
				SRC_PLL:  ROOT_CLK_O <= sync2_r[3] &
					(state_nxt == PLL_LOCKED);
				default:  ROOT_CLK_O <= 1'b0;
			endcase
		end
	end

endmodule : fpcs_top

// file: tb/fpcs_monitor.sv
/* fpcs_monitor: port assertions for fpcs_top.
 * assumes a bind to fpcs_top that passes the lock parameter on. */
`timescale 1ns/1ps
module fpcs_monitor import fpcs_pkg::*; #(
	parameter int LOCK_CYCLES_P = 16
) (
	// clock, reset and apb
	input wire logic        CLK_I,
	input wire logic        ARST_N_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [7:0]  PADDR_I,
	input wire logic        PREADY_O,
	input wire logic        PSLVERR_O,
	// clock pins
	input wire logic        MCLK_I,
	input wire logic        BCLK_I,
	input wire logic        GPIO_CLK_I,
	input wire logic        PLL_CORE_CLK_I,
	// pll and root results
	input wire logic        PLL_EN_O,
	input wire logic [3:0]  PLL_P_O,
	input wire logic [13:0] PLL_D_O,
	input wire logic        PLL_LOCKED_O,
	input wire logic        PLL_CLK_O,
	input wire logic        PLL_GPIO_CLK_O,
	input wire logic        ROOT_CLK_O,
	input wire logic [1:0]  ROOT_SEL_O
);
	logic [3:0] up_r;
	logic [3:0] srcs;
	logic       sel_clk;
	logic       wr_lo;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!ARST_N_I);
	// cycles since reset; stable windows must not reach back into reset
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) up_r <= 4'h0;
		else if (up_r != 4'hF) up_r <= up_r + 4'h1;
	end
	// expected root source and the commit strobe of the lower fraction
	assign srcs    = {PLL_CORE_CLK_I & PLL_LOCKED_O, GPIO_CLK_I, BCLK_I,
		MCLK_I};
	assign sel_clk = srcs[ROOT_SEL_O];
	assign wr_lo   = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I
		&& PADDR_I == {IDX_FRAC_LO, 2'b00};
	ready_wait_a: assert property ($rose(PENABLE_I) && PSEL_I |=> PREADY_O)
		else $error("apb answer not one wait state");
	ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready longer than one cycle");
	err_ready_a: assert property (PSLVERR_O |-> PREADY_O)
		else $error("error without ready");
	p_range_a: assert property (PLL_P_O inside {[4'h1:4'h8]})
		else $error("divide value out of range");
	frac_commit_a: assert property ($changed(PLL_D_O) |->
		$past(wr_lo) || $past(wr_lo, 2))
		else $error("fraction changed without lower write");
	lock_hold_a: assert property ($rose(PLL_EN_O) |->
		!PLL_LOCKED_O [*8])
		else $error("lock too early");
	lock_time_a: assert property ($rose(PLL_LOCKED_O) |->
		$past(PLL_EN_O, LOCK_CYCLES_P-2))
		else $error("lock before interval");
	pll_off_a: assert property (!PLL_EN_O ##1 !PLL_EN_O |->
		!PLL_LOCKED_O)
		else $error("lock while disabled");
	clk_gate_a: assert property (!PLL_LOCKED_O [*2] |-> !PLL_CLK_O)
		else $error("pll clock not gated");
	gpio_gate_a: assert property (PLL_GPIO_CLK_O |->
		PLL_CLK_O || $past(PLL_CLK_O))
		else $error("gpio clock without pll clock");
	root_mux_a: assert property (
		(up_r == 4'hF && $stable(sel_clk) && $stable(ROOT_SEL_O)) [*8]
		|-> ROOT_CLK_O == sel_clk)
		else $error("root clock not the selected source");
	cover property ($rose(PLL_LOCKED_O));
	cover property (PSLVERR_O);
	cover property (ROOT_SEL_O == SRC_PLL && ROOT_CLK_O);
endmodule : fpcs_monitor

// file: tb/fpcs_ref_model.sv
/* fpcs_ref_model: reference clock pins and the analog pll core.
 * assumes nothing but the block's pll power output. */
`timescale 1ns/1ps
module fpcs_ref_model (
	// pll power from the block
	input  wire logic en_i,
	// reference and core clocks
	output logic      mclk_o,
	output logic      bclk_o,
	output logic      gclk_o,
	output logic      pclk_o
);
	// start low so the sampled copies are defined at once
	initial begin
		mclk_o = 1'b0;
		bclk_o = 1'b0;
		gclk_o = 1'b0;
		pclk_o = 1'b0;
	end
	// free running references; half periods are multiples of 4 ns, so edges land on the system clock grid
	always #100 mclk_o = ~mclk_o;
	always #140 bclk_o = ~bclk_o;
	always #204 gclk_o = ~gclk_o;
	// the core only oscillates while powered
	always #124 pclk_o = en_i ? ~pclk_o : 1'b0;
endmodule : fpcs_ref_model

// file: tb/fpcs_top_test.sv
/* fpcs_top_test: self-checking bench for fpcs_top over apb.
 * assumes fpcs_ref_model drives the clock pins. */
`timescale 1ns/1ps
module fpcs_top_test;
	import fpcs_pkg::*;
	localparam int LOCK = 16;
	logic        clk, rst_n, psel, pen, pwr, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        mclk, bclk, gclk, pclk, en, locked, pll_clk, gpio_clk;
	logic        root_clk, range;
	logic [3:0]  p, r;
	logic [5:0]  j;
	logic [13:0] d;
	logic [1:0]  rsel;
	int          fails, check_count;
	fpcs_top #(.LOCK_CYCLES_P(LOCK)) DUT (.CLK_I(clk), .ARST_N_I(rst_n),
		.PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .MCLK_I(mclk), .BCLK_I(bclk), .GPIO_CLK_I(gclk),
		.PLL_CORE_CLK_I(pclk), .PLL_EN_O(en), .PLL_P_O(p), .PLL_R_O(r),
		.PLL_J_O(j), .PLL_D_O(d), .PLL_RANGE_O(range), .PLL_LOCKED_O(locked),
		.PLL_CLK_O(pll_clk), .PLL_GPIO_CLK_O(gpio_clk), .ROOT_CLK_O(root_clk),
		.ROOT_SEL_O(rsel));
	fpcs_ref_model REF (.en_i(en), .mclk_o(mclk), .bclk_o(bclk),
		.gclk_o(gclk), .pclk_o(pclk));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one apb transfer; ready is sampled at the rising edge where the
	// write lands, read data is taken there, and only then released
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] x;
		logic e;
		apb(1'b1, a, wd, x, e);
		repeat (3) @(negedge clk);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		logic e;
		apb(1'b0, a, 32'h0000_0000, x, e);
		check(x, exp);
		check(e, !(a inside {[8'h10:8'h27]}));
	endtask : rdc
	task automatic t_reset;
		logic [7:0] rv [5] = '{8'h00, 8'h11, 8'h04, 8'h00, 8'h00};
		check({p, r, j}, {4'h1, 4'h1, 6'h04});
		for (int i = 0; i < 5; i++) rdc(8'h10 + 8'(4 * i), rv[i]);
		wr(8'h3C, 32'h0000_00FF);
		rdc(8'h3C, 32'h0000_0000);
	endtask : t_reset
	task automatic t_frac;
		wr(8'h1C, 32'h0000_0027);
		check(d, 14'h0000);
		wr(8'h20, 32'h0000_000F);
		check(d, D_MAX);
		rdc(8'h1C, 32'h0000_0027);
	endtask : t_frac
	task automatic t_div;
		wr(8'h14, 32'h0000_0003);
		check({en, p, r}, {1'b0, 4'h8, 4'h3});
		wr(8'h18, 32'h0000_003F);
		check(j, 6'h3F);
		wr(8'h14, 32'h0000_0080);
		check(en, 1'b0);
		rdc(8'h24, 32'h0000_0004);
	endtask : t_div
	// lock, then route every root source; pll up first and down last
	// zero fraction keeps the slow reference legal; 5 MHz x 4 x 5 = 100 MHz
	task automatic t_lock;
		int n;
		wr(8'h1C, 32'h0000_0000);
		wr(8'h20, 32'h0000_0000);
		wr(8'h18, 32'h0000_0005);
		check(d, 14'h0000);
		wr(8'h14, 32'h0000_0094);
		n = 3;
		while (locked !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
		check({en, p, r}, {1'b1, 4'h1, 4'h4});
		check(n >= LOCK && n <= LOCK + 4, 1'b1);
		for (int c = 0; c < 4; c++) begin
			wr(8'h10, 32'h0000_0040 | c);
			check({range, rsel}, {1'b1, 2'(c)});
			repeat (40) @(negedge clk);
		end
		wr(8'h24, 32'h0000_0001);
		n = 0;
		while (gpio_clk !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		check(gpio_clk, 1'b1);
		wr(8'h10, 32'h0000_0000);
		wr(8'h14, 32'h0000_0014);
		check({en, locked, pll_clk}, 3'b000);
	endtask : t_lock
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	// free running system clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// watchdog well beyond the few hundred cycles of the run
	initial begin
		#100000;
		fails++;
		finish_test();
	end
	// main sequence
	initial begin
		{rst_n, psel, pen, pwr, paddr, pwdata} = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		t_reset();
		t_frac();
		t_div();
		t_lock();
		finish_test();
	end
endmodule : fpcs_top_test
bind fpcs_top fpcs_monitor #(.LOCK_CYCLES_P(LOCK_CYCLES_P)) u_mon (
	.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
	.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .MCLK_I(MCLK_I),
	.BCLK_I(BCLK_I), .GPIO_CLK_I(GPIO_CLK_I),
	.PLL_CORE_CLK_I(PLL_CORE_CLK_I), .PLL_EN_O(PLL_EN_O),
	.PLL_P_O(PLL_P_O), .PLL_D_O(PLL_D_O), .PLL_LOCKED_O(PLL_LOCKED_O),
	.PLL_CLK_O(PLL_CLK_O), .PLL_GPIO_CLK_O(PLL_GPIO_CLK_O),
	.ROOT_CLK_O(ROOT_CLK_O), .ROOT_SEL_O(ROOT_SEL_O));
